// ==== cbtt_target.v ====
// Target-side bus cycle control: claim, data phases, disconnect,
// retry and target-abort. Assumes one clock and synchronous pins.
//
// Function
// RULE1: Target-abort is stop asserted with device select negated.
// RULE2: Before abort, device select held one clock, target-ready negated.
// RULE3: Disconnect or retry keeps device select asserted with stop.
// RULE4: Stop held until frame sampled negated, released next cycle.
// RULE5: Data moves whenever both readies are asserted, regardless of stop.
// RULE6: At most one transfer after stop; ready with stop gives exactly one.
// RULE7: Ready asserted with stop drops once that phase completes.
// RULE8: Stop never released to continue the same transaction.
// RULE9: Wait in last phase delays stop until ready to finish.
// RULE10: Retry is a disconnect with no data moved.
// RULE11: Targets support retry; masters handle all termination forms.
// RULE12: Master negates frame on first ready clock after sampling stop.
// RULE13: Master may assert ready at once when stop without target-ready.
// RULE14: Target relies on no fixed stop-to-frame delay.
// RULE15: Final phase ends on first stop or ready clock; idle follows.
// RULE16: Master reissues from first untransferred word, or abandons.
// RULE17: Select, ready and stop stay fixed until the phase completes.
// RULE18: Master drops request two clocks after target termination.
// RULE19: Master reasserts request right after gap to finish access; the master model abandons a cut burst instead.
// RULE20: Each master has own request and grant, arbitrates per access.
// RULE21: Arbitration overlaps the ongoing access.
// RULE22: Arbiter never asserts more than one grant per clock.
// RULE23: Bus busy while frame or initiator-ready asserted.
`include "cbtt_regs.vh"

module cbtt_target (
  // Clock and control
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  // Bus inputs from the master
  input wire cycle_frame_n,
  input wire initiator_ready_n,
  // User side: decode, readiness and wanted ending
  input wire addr_hit,
  input wire user_ready,
  input wire [1:0] user_term,
  // Target bus pins
  output reg device_select_n,
  output reg target_ready_n,
  output reg target_stop_n,
  // Pin drivers, high while driving
  output reg device_select_oe,
  output reg target_ready_oe,
  output reg target_stop_oe,
  // Status towards the user side
  output reg data_strobe,
  output reg [1:0] done_kind,
  output reg done_strobe,
  output reg busy
);

  ////////////////////////////////////////////////////////////////////
  // Bus tracking
  wire bus_idle;
  wire xfer;
  wire phase_done;
  wire last_phase;

  cbtt_bus_watch u_watch (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .cycle_frame_n(cycle_frame_n),
    .initiator_ready_n(initiator_ready_n),
    .target_ready_n(target_ready_n),
    .target_stop_n(target_stop_n),
    .bus_idle_q(bus_idle),
    .xfer(xfer),
    .phase_done(phase_done),
    .last_phase(last_phase)
  );

  ////////////////////////////////////////////////////////////////////
  // State
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg sel_d;
  reg rdy_d;
  reg stp_d;
  reg oe_d;
  reg moved_q;
  reg moved_d;
  reg [1:0] kind_q;
  reg [1:0] kind_d;
  reg done_d;

  ////////////////////////////////////////////////////////////////////
  // User request decode
  wire want_abort;
  wire want_retry;
  wire want_disc;
  wire abort_ok;

  assign want_abort = (user_term == `CBTT_TERM_ABORT);
  assign want_retry = (user_term == `CBTT_TERM_RETRY);
  assign want_disc = (user_term == `CBTT_TERM_DISC);
  // Abort only after a select clock, with ready and stop still high
  assign abort_ok = ~device_select_n & target_ready_n & target_stop_n; // [RULE2]

  ////////////////////////////////////////////////////////////////////
  // Next-state and pin values
  always @* begin
    state_d = state_q;
    sel_d = device_select_n;
    rdy_d = target_ready_n;
    stp_d = target_stop_n;
    oe_d = device_select_oe;
    moved_d = moved_q | xfer;
    kind_d = kind_q;
    done_d = 1'b0;
    case (state_q)
      // Waiting for an address phase on an idle bus
      `CBTT_ST_IDLE: begin
        moved_d = 1'b0;
        // Claim an address phase: frame low out of an idle bus
        if (bus_idle && !cycle_frame_n && addr_hit) begin
          state_d = `CBTT_ST_CLAIM;
          sel_d = 1'b0;
          oe_d = 1'b1;
        end
      end

      // Claim cycle: pick the ending from the user request
      `CBTT_ST_CLAIM: begin
        // Select has now stood at least one clock
        if (want_abort && abort_ok) begin
          sel_d = 1'b1; // [RULE1] [RULE2]
          stp_d = 1'b0;
          kind_d = `CBTT_TERM_ABORT;
          state_d = `CBTT_ST_ABORT;
        end else if (want_retry) begin
          stp_d = 1'b0; // [RULE10] [RULE11] [RULE3]
          kind_d = `CBTT_TERM_RETRY;
          state_d = `CBTT_ST_STOP;
        end else begin
          state_d = `CBTT_ST_DATA;
          rdy_d = ~user_ready;
          // Stop only together with readiness to finish
          if (want_disc && user_ready) begin
            stp_d = 1'b0; // [RULE9] [RULE6]
            kind_d = `CBTT_TERM_DISC;
            state_d = `CBTT_ST_STOP;
          end
        end
      end

      // Data phases until an ending is due
      `CBTT_ST_DATA: begin
        // Pins frozen until the phase completes
        if (phase_done || target_ready_n) begin // [RULE17]
          if (last_phase) begin
            rdy_d = 1'b1; // [RULE15]
            sel_d = 1'b1;
            kind_d = `CBTT_TERM_NONE;
            done_d = 1'b1;
            state_d = `CBTT_ST_TURN;
          end else if (want_abort && abort_ok) begin
            sel_d = 1'b1; // [RULE1] [RULE2]
            stp_d = 1'b0;
            kind_d = `CBTT_TERM_ABORT;
            state_d = `CBTT_ST_ABORT;
          end else if (want_retry && target_ready_n) begin
            // Reported as disconnect later if a word already moved
            stp_d = 1'b0; // [RULE3] [RULE10]
            kind_d = `CBTT_TERM_RETRY;
            state_d = `CBTT_ST_STOP;
          end else if (want_disc && user_ready) begin
            rdy_d = 1'b0; // [RULE6] [RULE9]
            stp_d = 1'b0;
            kind_d = `CBTT_TERM_DISC;
            state_d = `CBTT_ST_STOP;
          end else begin
            rdy_d = ~user_ready;
          end
        end
      end

      // Disconnect or retry: stop low until frame is released
      `CBTT_ST_STOP: begin
        // One transfer at most, then ready drops
        if (xfer) begin
          rdy_d = 1'b1; // [RULE7] [RULE6]
        end
        // Stop kept until frame negated; no fixed wait assumed
        if (cycle_frame_n && phase_done) begin // [RULE4] [RULE14] [RULE8]
          stp_d = 1'b1;
          sel_d = 1'b1;
          rdy_d = 1'b1;
          done_d = 1'b1;
          state_d = `CBTT_ST_TURN;
        end
        if (kind_q == `CBTT_TERM_RETRY && moved_d) begin
          kind_d = `CBTT_TERM_DISC;
        end
      end

      // Target-abort: stop low with select already released
      `CBTT_ST_ABORT: begin
        // Abort stop also held until frame negated
        if (cycle_frame_n && !initiator_ready_n) begin // [RULE4]
          stp_d = 1'b1;
          done_d = 1'b1;
          state_d = `CBTT_ST_TURN;
        end
      end
      `CBTT_ST_TURN: begin
        // Release the pins one clock after driving them high
        sel_d = 1'b1;
        rdy_d = 1'b1;
        stp_d = 1'b1;
        oe_d = 1'b0;
        state_d = `CBTT_ST_IDLE;
      end

      // Unused codes fall back to idle with pins negated
      default: begin
        state_d = `CBTT_ST_IDLE;
        moved_d = 1'b0;
        kind_d = `CBTT_TERM_NONE;
        sel_d = `CBTT_NEG;
        rdy_d = `CBTT_NEG;
        stp_d = `CBTT_NEG;
        oe_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Registers and outputs

  // Control state and transaction bookkeeping
  always @(posedge core_clk) begin
    if (reset) begin
      state_q <= `CBTT_ST_IDLE;
      moved_q <= 1'b0;
      kind_q <= `CBTT_TERM_NONE;
    end else if (clk_en) begin
      state_q <= state_d;
      moved_q <= moved_d;
      kind_q <= kind_d;
    end
  end

  // Bus pins, negated out of reset
  always @(posedge core_clk) begin
    if (reset) begin
      device_select_n <= `CBTT_NEG;
      target_ready_n <= `CBTT_NEG;
      target_stop_n <= `CBTT_NEG;
    end else if (clk_en) begin
      device_select_n <= sel_d; // [RULE3]
      target_ready_n <= rdy_d;
      target_stop_n <= stp_d; // [RULE4]
    end
  end

  // Output enables: the three pins are driven together
  always @(posedge core_clk) begin
    if (reset) begin
      device_select_oe <= 1'b0;
      target_ready_oe <= 1'b0;
      target_stop_oe <= 1'b0;
    end else if (clk_en) begin
      device_select_oe <= oe_d;
      target_ready_oe <= oe_d;
      target_stop_oe <= oe_d;
    end
  end

  // Word strobe, one per clock with both readies low
  always @(posedge core_clk) begin
    if (reset) begin
      data_strobe <= 1'b0;
    end else if (clk_en) begin
      data_strobe <= xfer; // [RULE5]
    end
  end

  // End report; the kind stays until the next end
  always @(posedge core_clk) begin
    if (reset) begin
      done_strobe <= 1'b0;
      done_kind <= `CBTT_TERM_NONE;
    end else if (clk_en) begin
      done_strobe <= done_d;
      if (done_d) begin
        done_kind <= kind_d;
      end
    end
  end

  // Busy from claim to the end of turnaround
  always @(posedge core_clk) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (clk_en) begin
      busy <= (state_d != `CBTT_ST_IDLE); // [RULE23]
    end
  end

endmodule

// ==== cbtt_regs.vh ====
// Constants for the card bus target termination block.
// Assumes inclusion by bare name from the design files.
`ifndef CBTT_REGS_VH
`define CBTT_REGS_VH

// Target control states
`define CBTT_ST_IDLE 3'h0
`define CBTT_ST_CLAIM 3'h1
`define CBTT_ST_DATA 3'h2
`define CBTT_ST_STOP 3'h3
`define CBTT_ST_ABORT 3'h4
`define CBTT_ST_TURN 3'h5

// Termination kinds requested by the user side
`define CBTT_TERM_NONE 2'h0
`define CBTT_TERM_DISC 2'h1
`define CBTT_TERM_RETRY 2'h2
`define CBTT_TERM_ABORT 2'h3

// Reset level of the active-low bus outputs
`define CBTT_NEG 1'h1

`endif

// ==== cbtt_bus_watch.v ====
// Bus state tracker: busy/idle and final data phase of the bus.
// Assumes bus inputs are synchronous to core_clk.
`include "cbtt_regs.vh"

module cbtt_bus_watch (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire cycle_frame_n,
  input wire initiator_ready_n,
  input wire target_ready_n,
  input wire target_stop_n,
  output reg bus_idle_q,
  output wire xfer,
  output wire phase_done,
  output wire last_phase
);

  // Data moves whenever both readies are low, stop notwithstanding
  assign xfer = ~initiator_ready_n & ~target_ready_n; // [RULE5]
  // A data phase ends on a transfer or on stop with the master ready
  assign phase_done = ~initiator_ready_n & (~target_ready_n | ~target_stop_n);
  // Final phase ends the transaction
  assign last_phase = cycle_frame_n & phase_done; // [RULE15]

  // Bus idle only with frame and initiator-ready both negated
  always @(posedge core_clk) begin
    if (reset) begin
      bus_idle_q <= 1'b1;
    end else if (clk_en) begin
      bus_idle_q <= cycle_frame_n & initiator_ready_n; // [RULE23]
    end
  end

endmodule

// ==== cbtt_target_sva.sv ====
// Checker for the target's bus handshake and termination.
// Assumes one clock, synchronous active-high reset, clk_en held high.
module cbtt_target_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cycle_frame_n,
  input wire logic initiator_ready_n,
  input wire logic device_select_n,
  input wire logic target_ready_n,
  input wire logic target_stop_n,
  input wire logic data_strobe,
  input wire logic [1:0] done_kind,
  input wire logic done_strobe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////
  // Abort needs a prior select clock and target-ready high
  a_abort_after_sel: assert property (
    $fell(target_stop_n) && device_select_n |-> $past(!device_select_n) && target_ready_n)
    else $error("abort without prior select");
  a_abort_report: assert property (
    !target_stop_n && device_select_n && cycle_frame_n && !initiator_ready_n
    |=> done_strobe && done_kind == 2'h3)
    else $error("abort not reported");
  a_disc_keeps_sel: assert property (
    !target_stop_n && !device_select_n |=> target_stop_n || !device_select_n)
    else $error("select dropped under stop");
  a_stop_holds: assert property (
    !target_stop_n && !cycle_frame_n |=> !target_stop_n)
    else $error("stop released early");
  a_stop_drops: assert property (
    !target_stop_n && cycle_frame_n |=> target_stop_n)
    else $error("stop held too long");
  a_data_moves: assert property (
    data_strobe == $past(!initiator_ready_n && !target_ready_n))
    else $error("word move mismatch");
  a_one_more_word: assert property (
    !target_ready_n && !target_stop_n && !initiator_ready_n |=> target_ready_n)
    else $error("ready kept after stop word");
  a_final_end: assert property (
    cycle_frame_n && !initiator_ready_n && (!target_stop_n || !target_ready_n)
    |=> target_stop_n && target_ready_n && device_select_n)
    else $error("pins not released at end");
  a_phase_fixed: assert property (
    (!target_ready_n || !target_stop_n) && initiator_ready_n
    |=> $stable({device_select_n, target_ready_n, target_stop_n}))
    else $error("pins changed mid phase");

  // Main endings seen
  c_disc: cover property (done_strobe && done_kind == 2'h1);
  c_retry: cover property (done_strobe && done_kind == 2'h2);
  c_abort: cover property (done_strobe && done_kind == 2'h3);
endmodule

bind cbtt_target cbtt_target_sva u_sva (.core_clk(core_clk), .reset(reset),
  .cycle_frame_n(cycle_frame_n), .initiator_ready_n(initiator_ready_n),
  .device_select_n(device_select_n), .target_ready_n(target_ready_n),
  .target_stop_n(target_stop_n), .data_strobe(data_strobe),
  .done_kind(done_kind), .done_strobe(done_strobe));

// ==== cbtt_master.sv ====
// Bus master model: three-word burst, ends early on target stop.
// Assumes go pulses only while the bus is idle; holds the lone arbiter.
module cbtt_master (
  input wire logic core_clk,
  input wire logic go,
  input wire logic slow,
  input wire logic target_ready_n,
  input wire logic target_stop_n,
  output logic cycle_frame_n,
  output logic initiator_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  int n = 3;
  int gap = 0;
  logic t, s, g, gn, rq, start;
  logic want = 1'b0;
  logic bus_request_n = 1'b1;
  logic bus_grant_n = 1'b1;

  // Idle is frame and ready both high
  initial begin
    cycle_frame_n = 1'b1;
    initiator_ready_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // Sample at the edge, drive just after it
  always @(posedge core_clk) begin
    t = target_ready_n;
    s = target_stop_n;
    g = go;
    gn = bus_grant_n;
    rq = bus_request_n;
    #1;
    // Lone requester: one grant line, granted even mid-access
    bus_grant_n = rq;
    // Each access arbitrated alone; request only when needed
    want = want | g;
    if (gap > 0) gap = gap - 1;
    start = ph == 0 && want && !gn && gap == 0;
    if (start) want = 1'b0;
    bus_request_n = !(want && gap == 0);
    if (start) begin
      cycle_frame_n = 1'b0;
      n = 3;
      ph = 1;
    end else if (ph == 1) begin
      initiator_ready_n = slow;
      ph = 2;
    end else if (ph == 2) begin
      if (!initiator_ready_n && (!t || !s) && cycle_frame_n) begin
        initiator_ready_n = 1'b1;
        // Cut bursts are dropped like a prefetch; request off two clocks
        if (!s) gap = 2;
        ph = 0;
      end else if (!s) begin
        cycle_frame_n = 1'b1;
        initiator_ready_n = 1'b0;
      end else begin
        if (!initiator_ready_n && !t) begin
          if (n == 2) cycle_frame_n = 1'b1;
          n = n - 1;
        end
        initiator_ready_n = 1'b0;
      end
    end
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench: all termination kinds, random master waits.
// Assumes the target and master model compile alongside.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, clk_en = 1, addr_hit = 1, user_ready = 0, go = 0, slow = 0;
  logic [1:0] user_term = 2'h0;
  wire cycle_frame_n, initiator_ready_n, device_select_n, target_ready_n, target_stop_n;
  wire data_strobe, done_strobe, busy, sel_oe, rdy_oe, stp_oe;
  wire [1:0] done_kind;
  int err_count = 0, cmp_count = 0, seen = 0, r, k;

  cbtt_target u_cbtt_target (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .cycle_frame_n(cycle_frame_n), .initiator_ready_n(initiator_ready_n),
    .addr_hit(addr_hit), .user_ready(user_ready), .user_term(user_term),
    .device_select_n(device_select_n), .target_ready_n(target_ready_n),
    .target_stop_n(target_stop_n), .device_select_oe(sel_oe), .target_ready_oe(rdy_oe),
    .target_stop_oe(stp_oe), .data_strobe(data_strobe), .done_kind(done_kind),
    .done_strobe(done_strobe), .busy(busy));
  cbtt_master u_cbtt_master (.core_clk(core_clk), .go(go), .slow(slow),
    .target_ready_n(target_ready_n), .target_stop_n(target_stop_n),
    .cycle_frame_n(cycle_frame_n), .initiator_ready_n(initiator_ready_n));

  ////////////////////////////////////////////////////////////////
  // Clock, random user readiness, word counter
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) #1 user_ready = ($urandom % 4) != 0;
  always @(posedge core_clk) if (data_strobe === 1'b1) seen++;

  task check(input string name, input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Words moved per kind: burst, one after stop, none
  function logic [3:0] words_for(input int kd);
    return kd == 0 ? 4'h3 : (kd == 1 ? 4'h1 : 4'h0);
  endfunction

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One transaction of the given kind, then turnaround and idle
  task run(input int kd);
    int n;
    user_term = kd[1:0];
    seen = 0;
    go = 1;
    @(posedge core_clk) #1 go = 0;
    n = 0;
    while (done_strobe !== 1'b1 && n < 200) begin
      @(posedge core_clk) #1;
      n++;
    end
    check("done_kind", {2'h0, done_kind}, kd[3:0]);
    check("oe_turn", {1'h0, sel_oe, rdy_oe, stp_oe}, 4'h7);
    repeat (4) @(posedge core_clk) #1;
    check("oe_idle", {1'h0, sel_oe, rdy_oe, stp_oe}, 4'h0);
    check("words", seen[3:0], words_for(kd));
    check("busy", {3'h0, busy}, 4'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  // Every kind once, then random kinds and master waits
  initial begin
    r = $urandom(94);
    repeat (4) @(posedge core_clk);
    #1 reset = 0;
    repeat (2) @(posedge core_clk) #1;
    check("pins", {1'h0, device_select_n, target_ready_n, target_stop_n}, 4'h7);
    for (int i = 0; i < 24; i++) begin
      k = i < 4 ? i : $urandom % 4;
      slow = $urandom % 2;
      run(k);
    end
    give_verdict;
  end

  // Hang guard
  initial begin
    repeat (10000) @(posedge core_clk);
    err_count++;
    give_verdict;
  end
endmodule
